/* sct_status_pkg.sv */
// Constants for the SCT command decoder and status page builder.
// Assumes a single 200 MHz clock domain and taskfile values presented as plain ports.
package sct_status_pkg;

  // ----------------------------------------
  // Taskfile codes
  // ----------------------------------------
  localparam logic [7:0] CMD_SMART        = 8'hB0;
  localparam logic [7:0] CMD_READ_LOG_EXT = 8'h2F;
  localparam logic [7:0] CMD_WRITE_LOG_EXT= 8'h3F;
  localparam logic [7:0] FEAT_SMART_READ  = 8'hD5;
  localparam logic [7:0] FEAT_SMART_WRITE = 8'hD6;
  localparam logic [7:0] SMART_SIG_LO     = 8'h4F;
  localparam logic [7:0] SMART_SIG_HI     = 8'hC2;
  localparam logic [7:0] LOG_STATUS       = 8'hE0;
  localparam logic [7:0] LOG_DATA         = 8'hE1;
  localparam logic [7:0] ONE_SECTOR       = 8'h01;

  // ----------------------------------------
  // Status page layout
  // ----------------------------------------
  localparam logic [15:0] FORMAT_VERSION  = 16'h0003;
  localparam logic [15:0] SPEC_LEVEL      = 16'h0001;
  localparam logic [15:0] EXT_BUSY        = 16'hFFFF;
  localparam logic [15:0] EXT_NO_SCT_CMD  = 16'h000B;
  localparam logic [15:0] EXT_RESET       = 16'h0000;
  localparam logic [8:0]  BYTE_FMT_LO     = 9'h000;
  localparam logic [8:0]  BYTE_FMT_HI     = 9'h001;
  localparam logic [8:0]  BYTE_VER_LO     = 9'h002;
  localparam logic [8:0]  BYTE_VER_HI     = 9'h003;
  localparam logic [8:0]  BYTE_SPEC_LO    = 9'h004;
  localparam logic [8:0]  BYTE_SPEC_HI    = 9'h005;
  localparam logic [8:0]  BYTE_FLAGS0     = 9'h006;
  localparam logic [8:0]  BYTE_DRIVE      = 9'h00A;
  localparam logic [8:0]  BYTE_EXT_LO     = 9'h00E;
  localparam logic [8:0]  BYTE_EXT_HI     = 9'h00F;
  localparam logic [8:0]  PAGE_LAST       = 9'h1FF;
  localparam int          FLAG_SEG_INIT   = 0;

  // ----------------------------------------
  // Drive state codes
  // ----------------------------------------
  typedef enum logic [7:0] {
    DRV_IDLE    = 8'h00,
    DRV_STANDBY = 8'h01,
    DRV_SLEEP   = 8'h02,
    DRV_SELFTST = 8'h03,
    DRV_OFFLINE = 8'h04,
    DRV_SCT_BG  = 8'h05
  } drive_state_t;

  // ----------------------------------------
  // Decoded request kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    REQ_NONE       = 3'b000,
    REQ_STATUS     = 3'b001,
    REQ_DATA_READ  = 3'b010,
    REQ_DATA_WRITE = 3'b011,
    REQ_OTHER      = 3'b100
  } req_kind_t;

endpackage : sct_status_pkg

/* sct_taskfile_decode.sv */
// Taskfile decoder: classifies one command as SCT status, SCT data or other.
// Assumes taskfile values are stable while cmd_valid is high.
`timescale 1ns/100ps
module sct_taskfile_decode (
  // Taskfile
  input  wire logic [7:0]               tf_command,
  input  wire logic [7:0]               tf_feature,
  input  wire logic [7:0]               tf_count,
  input  wire logic [7:0]               tf_count_prev,
  input  wire logic [7:0]               tf_lba_low,
  input  wire logic [7:0]               tf_lba_mid,
  input  wire logic [7:0]               tf_lba_mid_prev,
  input  wire logic [7:0]               tf_lba_high,
  // Result
  output sct_status_pkg::req_kind_t     req_kind
);

  logic smart_sig;
  logic ext_one;

  assign smart_sig = (tf_lba_mid == sct_status_pkg::SMART_SIG_LO) && (tf_lba_high == sct_status_pkg::SMART_SIG_HI);
  assign ext_one   = (tf_count == sct_status_pkg::ONE_SECTOR) && (tf_count_prev == 8'h00)
                     && (tf_lba_mid == 8'h00) && (tf_lba_mid_prev == 8'h00);

  always_comb begin
    req_kind = sct_status_pkg::REQ_OTHER;
    if (tf_command == sct_status_pkg::CMD_SMART && smart_sig) begin
      if (tf_feature == sct_status_pkg::FEAT_SMART_READ && tf_lba_low == sct_status_pkg::LOG_STATUS
          && tf_count == sct_status_pkg::ONE_SECTOR)
        req_kind = sct_status_pkg::REQ_STATUS;
      else if (tf_feature == sct_status_pkg::FEAT_SMART_READ && tf_lba_low == sct_status_pkg::LOG_DATA)
        req_kind = sct_status_pkg::REQ_DATA_READ;
      else if (tf_feature == sct_status_pkg::FEAT_SMART_WRITE && tf_lba_low == sct_status_pkg::LOG_DATA)
        req_kind = sct_status_pkg::REQ_DATA_WRITE;
    end else if (tf_command == sct_status_pkg::CMD_READ_LOG_EXT) begin
      if (tf_lba_low == sct_status_pkg::LOG_STATUS && ext_one)
        req_kind = sct_status_pkg::REQ_STATUS;
      else if (tf_lba_low == sct_status_pkg::LOG_DATA)
        req_kind = sct_status_pkg::REQ_DATA_READ;
    end else if (tf_command == sct_status_pkg::CMD_WRITE_LOG_EXT && tf_lba_low == sct_status_pkg::LOG_DATA) begin
      req_kind = sct_status_pkg::REQ_DATA_WRITE;
    end
  end

endmodule : sct_taskfile_decode

/* sct_status_log_responder.sv */
// SCT command decoder and status log page builder.
// Assumes the host presents taskfile values with a one-cycle cmd_valid strobe.
//
// What this block does
// - Taskfile status signals acceptance or error only
// - Status served as log page E0h
// - Status request accepted unless a page is already streaming, then refused
// - Status request changes no state
// - Log ext E1h 2Fh/3Fh is data transfer
// - SMART D5h E0h B0h is status request
// - Read log ext E0h is status request
// - Bytes 1:0 format version 0003h
// - Bytes 3:2 vendor implementation version
// - Bytes 5:4 spec level 0001h
// - Flag bit 0 set after full write-same
// - Any user LBA write clears flag
// - Capacity change clears flag; otherwise kept
// - Byte 10 encodes drive activity state
// - Bytes 15:14 extended status, FFFFh busy
// - Data transfer without SCT command gives 000Bh
// - SMART D5h/D6h E1h B0h is data transfer
`timescale 1ns/100ps
module sct_status_log_responder #(
  parameter logic [15:0] IMPL_VERSION = 16'h0100  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Taskfile command
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  tf_command,
  input  wire logic [7:0]  tf_feature,
  input  wire logic [7:0]  tf_count,
  input  wire logic [7:0]  tf_count_prev,
  input  wire logic [7:0]  tf_lba_low,
  input  wire logic [7:0]  tf_lba_mid,
  input  wire logic [7:0]  tf_lba_mid_prev,
  input  wire logic [7:0]  tf_lba_high,
  // Command outcome
  output logic             cmd_accept,
  output logic             cmd_error,
  output logic             data_xfer_read,
  output logic             data_xfer_write,
  // Status page stream
  output logic             page_valid,
  input  wire logic        page_ready,
  output logic [7:0]       page_data,
  output logic             page_last,
  // Drive activity and SCT engine
  input  wire logic [2:0]  drive_state,
  input  wire logic        sct_cmd_issued,
  input  wire logic        sct_bg_busy,
  input  wire logic        sct_done,
  input  wire logic [15:0] sct_done_code,
  // Segment-initialised flag events
  input  wire logic        seg_init_saved,
  input  wire logic        write_same_all_ok,
  input  wire logic        user_lba_write,
  input  wire logic        capacity_change,
  output logic             seg_init_flag
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        loaded;
    logic        seg_init;
    logic        sct_seen;
    logic [15:0] ext_code;
    logic        sending;
    logic [8:0]  idx;
    logic [7:0]  data;
    logic        accept;
    logic        error;
    logic        dread;
    logic        dwrite;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  sct_status_pkg::req_kind_t req_kind;
  logic [7:0]  byte_nxt;
  logic [8:0]  idx_sel;
  logic [15:0] ext_view;

  sct_taskfile_decode u_decode (
    .tf_command      (tf_command),
    .tf_feature      (tf_feature),
    .tf_count        (tf_count),
    .tf_count_prev   (tf_count_prev),
    .tf_lba_low      (tf_lba_low),
    .tf_lba_mid      (tf_lba_mid),
    .tf_lba_mid_prev (tf_lba_mid_prev),
    .tf_lba_high     (tf_lba_high),
    .req_kind        (req_kind)
  );

  // ----------------------------------------
  // Page byte builder
  // ----------------------------------------
  assign ext_view = sct_bg_busy ? sct_status_pkg::EXT_BUSY : st_r.ext_code;

  always_comb begin
    unique case (idx_sel)
      sct_status_pkg::BYTE_FMT_LO:  byte_nxt = sct_status_pkg::FORMAT_VERSION[7:0];
      sct_status_pkg::BYTE_FMT_HI:  byte_nxt = sct_status_pkg::FORMAT_VERSION[15:8];
      sct_status_pkg::BYTE_VER_LO:  byte_nxt = IMPL_VERSION[7:0];
      sct_status_pkg::BYTE_VER_HI:  byte_nxt = IMPL_VERSION[15:8];
      sct_status_pkg::BYTE_SPEC_LO: byte_nxt = sct_status_pkg::SPEC_LEVEL[7:0];
      sct_status_pkg::BYTE_SPEC_HI: byte_nxt = sct_status_pkg::SPEC_LEVEL[15:8];
      sct_status_pkg::BYTE_FLAGS0:  byte_nxt = {7'h00, st_r.seg_init};
      sct_status_pkg::BYTE_DRIVE:   byte_nxt = {5'h00, drive_state};
      sct_status_pkg::BYTE_EXT_LO:  byte_nxt = ext_view[7:0];
      sct_status_pkg::BYTE_EXT_HI:  byte_nxt = ext_view[15:8];
      default:                      byte_nxt = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Index of the byte loaded next
  // ----------------------------------------
  always_comb begin
    idx_sel = st_r.idx;
    if (cmd_valid && (req_kind == sct_status_pkg::REQ_STATUS) && !st_r.sending) begin
      idx_sel = sct_status_pkg::BYTE_FMT_LO;
    end else if (st_r.sending && page_ready && (st_r.idx != sct_status_pkg::PAGE_LAST)) begin
      idx_sel = st_r.idx + 9'h001;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.accept = 1'b0;
    st_nxt.error  = 1'b0;
    st_nxt.dread  = 1'b0;
    st_nxt.dwrite = 1'b0;

    // Flag restored once after reset, then kept
    if (!st_r.loaded) begin
      st_nxt.loaded   = 1'b1;
      st_nxt.seg_init = seg_init_saved;
    end else if (user_lba_write || capacity_change) begin
      st_nxt.seg_init = 1'b0;
    end else if (write_same_all_ok) begin
      st_nxt.seg_init = 1'b1;
    end

    if (sct_cmd_issued)
      st_nxt.sct_seen = 1'b1;
    if (sct_done)
      st_nxt.ext_code = sct_done_code;

    // Page streaming
    if (st_r.sending && page_ready) begin
      if (st_r.idx == sct_status_pkg::PAGE_LAST) begin
        st_nxt.sending = 1'b0;
      end else begin
        st_nxt.idx     = idx_sel;
        st_nxt.data    = byte_nxt;
      end
    end

    // Command taking; status never touches power or background work
    if (cmd_valid) begin
      unique case (req_kind)
        sct_status_pkg::REQ_STATUS: begin
          if (st_r.sending) begin
            st_nxt.error = 1'b1;
          end else begin
            st_nxt.accept  = 1'b1;
            st_nxt.sending = 1'b1;
            st_nxt.idx     = idx_sel;
            st_nxt.data    = byte_nxt;
          end
        end
        sct_status_pkg::REQ_DATA_READ,
        sct_status_pkg::REQ_DATA_WRITE: begin
          if (!st_r.sct_seen) begin
            st_nxt.error    = 1'b1;
            st_nxt.ext_code = sct_status_pkg::EXT_NO_SCT_CMD;
          end else begin
            st_nxt.accept = 1'b1;
            st_nxt.dread  = (req_kind == sct_status_pkg::REQ_DATA_READ);
            st_nxt.dwrite = (req_kind == sct_status_pkg::REQ_DATA_WRITE);
          end
        end
        default: begin
          st_nxt.accept = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{loaded: 1'b0, seg_init: 1'b0, sct_seen: 1'b0, ext_code: sct_status_pkg::EXT_RESET,
                sending: 1'b0, idx: 9'h000, data: 8'h00, accept: 1'b0, error: 1'b0,
                dread: 1'b0, dwrite: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_accept      = st_r.accept;
  assign cmd_error       = st_r.error;
  assign data_xfer_read  = st_r.dread;
  assign data_xfer_write = st_r.dwrite;
  assign page_valid      = st_r.sending;
  assign page_data       = st_r.data;
  assign page_last       = st_r.sending && (st_r.idx == sct_status_pkg::PAGE_LAST);
  assign seg_init_flag   = st_r.seg_init;

endmodule : sct_status_log_responder

/* sct_status_log_responder_properties.sv */
// Port checker for the SCT status responder.
// Assumes it is bound to sct_status_log_responder and sees only its ports.
`timescale 1ns/100ps
module sct_status_log_responder_properties (
  // Clock and reset
  input wire logic       ref_clk, resetn,
  // Taskfile and outcome
  input wire logic       cmd_valid, cmd_accept, cmd_error, data_xfer_read, data_xfer_write,
  input wire logic [7:0] tf_command, tf_feature, tf_count, tf_lba_low, tf_lba_mid, tf_lba_high,
  // Page stream and flag
  input wire logic       page_valid, page_ready, page_last,
  input wire logic [7:0] page_data,
  input wire logic       write_same_all_ok, user_lba_write, capacity_change, seg_init_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire sm  = cmd_valid && tf_command == 8'hB0 && tf_lba_mid == 8'h4F && tf_lba_high == 8'hC2;
  wire clr = user_lba_write || capacity_change;

  property p_excl; !(cmd_accept && cmd_error); endproperty
  a_excl: assert property (p_excl) else $error("accept and error together");
  property p_log_st;
    cmd_valid && tf_command == 8'h2F && tf_lba_low == 8'hE0 && tf_count == 8'h01 && !page_valid
      |=> cmd_accept && page_valid && page_data == 8'h03;
  endproperty
  a_log_st: assert property (p_log_st) else $error("log status not served");
  property p_smart_st;
    sm && tf_feature == 8'hD5 && tf_lba_low == 8'hE0 && tf_count == 8'h01 && !page_valid |=> cmd_accept && page_valid;
  endproperty
  a_smart_st: assert property (p_smart_st) else $error("smart status not served");
  property p_log_wr;
    cmd_valid && tf_command == 8'h3F && tf_lba_low == 8'hE1 |=> !data_xfer_read && (data_xfer_write || cmd_error);
  endproperty
  a_log_wr: assert property (p_log_wr) else $error("log write misdecoded");
  property p_smart_wr;
    sm && tf_feature == 8'hD6 && tf_lba_low == 8'hE1 |=> !data_xfer_read && (data_xfer_write || cmd_error);
  endproperty
  a_smart_wr: assert property (p_smart_wr) else $error("smart write misdecoded");
  property p_hold; page_valid && !page_ready |=> page_valid && $stable(page_data); endproperty
  a_hold: assert property (p_hold) else $error("page byte lost in stall");
  property p_end; page_valid && page_ready && page_last |=> !page_valid; endproperty
  a_end: assert property (p_end) else $error("page runs past last byte");
  property p_clear; clr |=> !seg_init_flag; endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_set; write_same_all_ok && !clr |=> seg_init_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  c_refuse: cover property (cmd_error);
  c_page_end: cover property (page_last && page_ready);
  c_write: cover property (data_xfer_write);
endmodule : sct_status_log_responder_properties

bind sct_status_log_responder sct_status_log_responder_properties u_props (.*);

/* sct_host_model.sv */
// Host model: issues taskfile commands and sinks status pages with stalls.
// Assumes inputs change at the rising edge of ref_clk; drives its outputs at the falling edge.
`timescale 1ns/100ps
module sct_host_model (
  // Clock and page stream
  input  wire logic        ref_clk,
  input  wire logic        page_valid,
  input  wire logic [7:0]  page_data,
  input  wire logic        page_last,
  output logic             page_ready,
  // Taskfile, command first, lba high last
  output logic             cmd_valid,
  output logic [63:0]      tf_bus
);
  logic [7:0] page [512];
  initial begin
    cmd_valid = 1'b0;
    tf_bus = 64'h0;
    page_ready = 1'b0;
  end
  // One-cycle command; fields turn to garbage afterwards
  task automatic issue(input logic [63:0] v);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    tf_bus = v;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    tf_bus = ~v;
  endtask : issue
  // Polls one status page, stalling one cycle in four
  // A byte seen here with ready raised is taken at the coming rising edge
  task automatic read_page(output int n, output int last_at);
    n = 0;
    last_at = -1;
    for (int k = 0; k < 2000 && last_at < 0; k++) begin
      @(negedge ref_clk);
      page_ready = (k % 4 != 3);
      if (page_valid === 1'b1 && page_ready) begin
        if (n < 512) page[n] = page_data;
        if (page_last === 1'b1) last_at = n;
        n++;
      end
    end
    @(negedge ref_clk);
    page_ready = 1'b0;
  endtask : read_page
endmodule : sct_host_model

/* sct_status_log_responder_tb.sv */
// Testbench for the SCT status responder: decoding, page contents, flag events.
// Assumes sct_host_model as host and the bound port checker.
`timescale 1ns/100ps
module sct_status_log_responder_tb;
  localparam logic [15:0] IMPL = 16'h5A3C;  // Arbitrary value
  localparam logic [63:0] ST_LOG = 64'h2F000100E0000000;
  localparam logic [63:0] ST_SM = 64'hB0D50100E04F00C2;
  localparam logic [63:0] XFER [4] = '{64'h2F000100E1000000, 64'h3F000100E1000000,
                                       64'hB0D50100E14F00C2, 64'hB0D60100E14F00C2};
  logic        ref_clk, resetn, cmd_valid, page_ready, sct_cmd_issued, sct_bg_busy, sct_done;
  logic        seg_init_saved, write_same_all_ok, user_lba_write, capacity_change;
  logic        cmd_accept, cmd_error, data_xfer_read, data_xfer_write, page_valid, page_last, seg_init_flag;
  logic [2:0]  drive_state;
  logic [7:0]  page_data;
  logic [15:0] sct_done_code;
  logic [63:0] tf_bus;
  int          num_errors = 0;
  int          check_count = 0;

  sct_host_model u_host (.*);
  sct_status_log_responder #(.IMPL_VERSION(IMPL)) u_dut (.*, .tf_command(tf_bus[63:56]),
    .tf_feature(tf_bus[55:48]), .tf_count(tf_bus[47:40]), .tf_count_prev(tf_bus[39:32]),
    .tf_lba_low(tf_bus[31:24]), .tf_lba_mid(tf_bus[23:16]), .tf_lba_mid_prev(tf_bus[15:8]),
    .tf_lba_high(tf_bus[7:0]));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic cmd(input logic [63:0] v, input logic acc);
    u_host.issue(v);
    check(cmd_accept, acc);
    check(cmd_error, !acc);
  endtask : cmd
  task automatic cmd_none(input logic [63:0] v);
    u_host.issue(v);
    check({cmd_accept, cmd_error, data_xfer_read, page_valid}, 16'h0000);
  endtask : cmd_none
  task automatic page_chk(input logic [15:0] ext, input logic [7:0] drv, input logic flag);
    int n, la;
    logic [7:0] rsv;
    u_host.read_page(n, la);
    rsv = 8'h00;
    for (int i = 7; i < 512; i++) if (i != 10 && i != 14 && i != 15) rsv |= u_host.page[i];
    check(16'(n), 16'h0200);
    check(16'(la), 16'h01FF);
    check(page_valid, 1'b0);
    check({u_host.page[1], u_host.page[0]}, sct_status_pkg::FORMAT_VERSION);
    check({u_host.page[3], u_host.page[2]}, IMPL);
    check({u_host.page[5], u_host.page[4]}, sct_status_pkg::SPEC_LEVEL);
    check(u_host.page[6], {7'h00, flag});
    check(u_host.page[10], drv);
    check({u_host.page[15], u_host.page[14]}, ext);
    check(rsv, 8'h00);
  endtask : page_chk
  task automatic pulse(input logic [2:0] ev, input logic exp);
    @(negedge ref_clk);
    {write_same_all_ok, user_lba_write, capacity_change} = ev;
    @(negedge ref_clk);
    {write_same_all_ok, user_lba_write, capacity_change} = 3'h0;
    check(seg_init_flag, exp);
  endtask : pulse

  // Both status routes, second request refused while streaming
  task automatic t_status();
    cmd(ST_SM, 1'b1);
    page_chk(16'h0000, 8'h00, 1'b1);
    cmd(ST_LOG, 1'b1);
    cmd(ST_SM, 1'b0);
    page_chk(16'h0000, 8'h00, 1'b1);
  endtask : t_status
  // Non-SCT commands, then data transfer with no SCT command before it
  task automatic t_no_sct();
    cmd_none(64'hB0D50100E0000000);
    cmd_none(64'h2F000200E0000000);
    cmd(XFER[0], 1'b0);
    check(data_xfer_read, 1'b0);
    cmd(ST_LOG, 1'b1);
    page_chk(sct_status_pkg::EXT_NO_SCT_CMD, 8'h00, 1'b1);
  endtask : t_no_sct
  task automatic t_flag();
    pulse(3'h2, 1'b0);
    pulse(3'h4, 1'b1);
    pulse(3'h1, 1'b0);
    pulse(3'h4, 1'b1);
    pulse(3'h6, 1'b0);
    pulse(3'h4, 1'b1);
  endtask : t_flag
  // Reset while a page waits at its first byte: stream dropped, flag restored, SCT history forgotten
  task automatic t_reset();
    cmd(ST_LOG, 1'b1);
    repeat (3) @(negedge ref_clk);
    resetn = 1'b0;
    @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    check(page_valid, 1'b0);
    check(seg_init_flag, 1'b1);
    cmd(XFER[1], 1'b0);
    cmd(ST_LOG, 1'b1);
    page_chk(sct_status_pkg::EXT_NO_SCT_CMD, 8'h05, 1'b1);
  endtask : t_reset
  // Background action: every drive state, both transfer routes, completion code
  task automatic t_busy();
    @(negedge ref_clk);
    sct_cmd_issued = 1'b1;
    sct_bg_busy = 1'b1;
    @(negedge ref_clk);
    sct_cmd_issued = 1'b0;
    for (int i = 0; i < 6; i++) begin
      drive_state = 3'(i);
      cmd(ST_LOG, 1'b1);
      page_chk(sct_status_pkg::EXT_BUSY, 8'(i), 1'b1);
      check(seg_init_flag, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      cmd(XFER[i], 1'b1);
      check(data_xfer_read, !i[0]);
      check(data_xfer_write, i[0]);
    end
    @(negedge ref_clk);
    sct_bg_busy = 1'b0;
    sct_done = 1'b1;
    sct_done_code = 16'h0002;
    @(negedge ref_clk);
    sct_done = 1'b0;
    cmd(ST_SM, 1'b1);
    page_chk(16'h0002, 8'h05, 1'b1);
  endtask : t_busy

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    {sct_cmd_issued, sct_bg_busy, sct_done, write_same_all_ok, user_lba_write, capacity_change} = 6'h00;
    seg_init_saved = 1'b1;
    drive_state = 3'h0;
    sct_done_code = 16'h0000;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    check(seg_init_flag, 1'b1);
    t_status();
    t_no_sct();
    t_flag();
    t_busy();
    t_reset();
    stop_test();
  end
endmodule : sct_status_log_responder_tb
